/* File: verilog/addr_match_pkg.sv */
// shared constants for the serial port target and its bus-side master
package addr_match_pkg;
  // ---------------------------------------------------------------
  // register offsets (apb byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CONTROL_ONE = 8'h00;
  localparam logic [7:0] OFF_CONTROL_TWO = 8'h04;
  localparam logic [7:0] OFF_ADDRESS     = 8'h08;
  localparam logic [7:0] OFF_BUFFER      = 8'h0C;
  localparam logic [7:0] OFF_STATUS      = 8'h10;
  localparam logic [7:0] OFF_FLAGS       = 8'h14;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int C1_OVERFLOW  = 6;
  localparam int C1_ENABLE    = 5;
  localparam int C1_RELEASE   = 4;
  localparam int C2_STRETCH   = 0;
  localparam int ST_UPDATE    = 1;
  localparam int ST_FULL      = 0;
  localparam int ST_RW        = 2;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CONTROL_ONE = 8'h10;
  localparam logic [7:0] RST_CONTROL_TWO = 8'h00;
  localparam logic [7:0] RST_ADDRESS     = 8'h00;
  // ---------------------------------------------------------------
  // mode field codes
  // ---------------------------------------------------------------
  localparam logic [3:0] MODE_SLAVE10_SP = 4'hF;
  localparam logic [3:0] MODE_SLAVE7_SP  = 4'hE;
  localparam logic [3:0] MODE_FW_MASTER  = 4'hB;
  localparam logic [3:0] MODE_MASTER     = 4'h8;
  localparam logic [3:0] MODE_SLAVE10    = 4'h7;
  localparam logic [3:0] MODE_SLAVE7     = 4'h6;
  localparam logic [4:0] TEN_BIT_HEADER  = 5'h1E;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
endpackage

/* File: verilog/i2c_link_if.sv */
// link between the apb-side master and the serial port target
`timescale 1ns/1ps
interface i2c_link_if;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        port_irq;
  modport target (
    input  psel, penable, pwrite, paddr, pwdata,
    output prdata, pready, pslverr, port_irq
  );
  modport software (
    output psel, penable, pwrite, paddr, pwdata,
    input  prdata, pready, pslverr, port_irq
  );
endinterface

/* File: verilog/i2c_target.sv */
// serial port target: address reception, match, acknowledge and masking
`timescale 1ns/1ps
// How it works
// - slave stretch bit enables receive stretching; transmit always stretches
// - master mode: bit starts Start, self-clears
// - while active, request bits cannot be set (master mode) and buffer writes ignored
// - address register: own address or baud value
// - four-bit mode field selects port mode
// - mode codes F,E,7,6,8 decoded; B is not
// - enabled i2c mode drives pins open-drain
// - slave transmitter drives data onto sda
// - flag on match; start/stop when mode allows
// - match or data byte: ack, load buffer
// - full or overflow: no ack, flag still
// - buffer read clears full; overflow by write
// - after Start shift 8 bits on scl rise
// - compare bits 7:1 (ten-bit low byte 7:0) masked at eighth fall
// - match loads, sets full, flag at ninth
// - ten-bit header 11110 a9 a8 w
// - ten-bit address bytes set update, reload clears
// - after repeated start header sets flag, full
// - 7-bit: mask bits 5:1 don't-care
// - 10-bit: mask 5:2, bit1 masks 1:0
// - software reads buffer to learn matched address
// - control two bits 5:1 are mask bits
module i2c_target
  import addr_match_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // register bus
  i2c_link_if.target      bus,
  // bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            scl_out,
  output logic            scl_oe,
  output logic            sda_out,
  output logic            sda_oe,
  // transmit data for slave transmitter
  input  wire logic [7:0] tx_byte
);
  typedef enum logic [3:0] {
    IDLE  = 4'b0001,
    SHIFT = 4'b0010,
    ACK   = 4'b0100,
    SEND  = 4'b1000
  } phase_e;

  typedef struct packed {
    phase_e     phase;
    logic [7:0] control_one;
    logic [7:0] control_two;
    logic [7:0] address;
    logic [7:0] buffer;
    logic [7:0] shift;
    logic [3:0] count;
    logic       full;
    logic       update;
    logic       flag;
    logic       rw;
    logic       matched;
    logic       ten_hi;
    logic       ack_drive;
    logic       scl_d;
    logic       sda_d;
    logic [7:0] tx;
    logic [2:0] start_step;
    logic [31:0] rdata;
  } state_s;

  state_s st_reg;
  state_s st_next;

  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic       enabled;
  logic       is_master;
  logic       is_ten;
  logic       slave_mode;
  logic       sp_irq;
  logic       active;
  logic       wr;
  logic       rd;
  logic [4:0] mask;
  logic [7:0] care;
  logic       addr_hit;
  logic       hdr_hit;

  // ---------------------------------------------------------------
  // mode decode and edges
  // ---------------------------------------------------------------
  always_comb
  begin
    scl_rise   = scl_in & ~st_reg.scl_d;
    scl_fall   = ~scl_in & st_reg.scl_d;
    start_seen = scl_in & st_reg.sda_d & ~sda_in;
    stop_seen  = scl_in & ~st_reg.sda_d & sda_in;
    enabled    = st_reg.control_one[C1_ENABLE];
    is_master  = st_reg.control_one[3:0] == MODE_MASTER;
    is_ten     = st_reg.control_one[3:0] == MODE_SLAVE10 ||
                 st_reg.control_one[3:0] == MODE_SLAVE10_SP;
    slave_mode = is_ten || st_reg.control_one[3:0] == MODE_SLAVE7 ||
                 st_reg.control_one[3:0] == MODE_SLAVE7_SP;
    sp_irq     = st_reg.control_one[3:0] == MODE_SLAVE10_SP ||
                 st_reg.control_one[3:0] == MODE_SLAVE7_SP;
    active     = st_reg.phase != IDLE || st_reg.start_step != 3'h0;
    wr         = bus.psel & bus.penable & bus.pwrite;
    rd         = bus.psel & bus.penable & ~bus.pwrite;
    mask       = st_reg.control_two[5:1];
    // clear bits in care are don't-care
    care       = 8'hFF;
    if (is_ten)
    begin
      care[5:2] = ~mask[4:1];
      care[1:0] = {2{~mask[0]}};
    end
    else
    begin
      care[5:1] = ~mask;
    end
    // 7-bit form compares shift 7:1 with address 7:1
    addr_hit = is_ten ? (((st_reg.shift ^ st_reg.address) & care) == 8'h00)
                      : ((((st_reg.shift ^ st_reg.address) & care) & 8'hFE) == 8'h00);
    hdr_hit  = st_reg.shift[7:3] == TEN_BIT_HEADER;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    st_next         = st_reg;
    st_next.scl_d   = scl_in;
    st_next.sda_d   = sda_in;
    st_next.rdata   = 32'h0000_0000;
    // register reads
    if (bus.psel & ~bus.penable & ~bus.pwrite)
    begin
      unique case (bus.paddr)
        OFF_CONTROL_ONE: st_next.rdata = {24'h0, st_reg.control_one};
        OFF_CONTROL_TWO: st_next.rdata = {24'h0, st_reg.control_two};
        OFF_ADDRESS:     st_next.rdata = {24'h0, st_reg.address};
        OFF_BUFFER:      st_next.rdata = {24'h0, st_reg.buffer};
        OFF_STATUS:      st_next.rdata = {29'h0, st_reg.rw, st_reg.update, st_reg.full};
        OFF_FLAGS:       st_next.rdata = {31'h0, st_reg.flag};
        default:         st_next.rdata = 32'h0000_0000;
      endcase
    end
    if (rd && bus.paddr == OFF_BUFFER)
      st_next.full = 1'b0;
    if (wr)
    begin
      unique case (bus.paddr)
        OFF_CONTROL_ONE: st_next.control_one = bus.pwdata[7:0];
        OFF_CONTROL_TWO:
        begin
          // in master mode, request bits may not be set while busy
          if (active && is_master)
            st_next.control_two = {bus.pwdata[7:5],
                                   st_reg.control_two[4:0] & bus.pwdata[4:0]};
          else
            st_next.control_two = bus.pwdata[7:0];
        end
        OFF_ADDRESS:
        begin
          st_next.address = bus.pwdata[7:0];
          st_next.update  = 1'b0;
        end
        OFF_BUFFER:
        begin
          if (!active)
            st_next.tx = bus.pwdata[7:0];
        end
        OFF_FLAGS: st_next.flag = st_reg.flag & ~bus.pwdata[0];
        default: ;
      endcase
    end
    // master-mode start: pull sda while scl high, then self-clear
    if (enabled && is_master)
    begin
      if (st_reg.start_step == 3'h0 && st_reg.control_two[C2_STRETCH])
        st_next.start_step = 3'h1;
      else if (st_reg.start_step != 3'h0)
      begin
        st_next.start_step = st_reg.start_step + 3'h1;
        if (st_reg.start_step == 3'h7)
        begin
          st_next.start_step = 3'h0;
          st_next.control_two[C2_STRETCH] = 1'b0;
        end
      end
    end
    if (enabled && slave_mode && (start_seen || stop_seen) && sp_irq)
      st_next.flag = 1'b1;
    if (!enabled || !slave_mode)
      st_next.phase = IDLE;
    else if (start_seen)
    begin
      st_next.phase   = SHIFT;
      st_next.count   = 4'h0;
      st_next.matched = 1'b0;
    end
    else if (stop_seen)
      st_next.phase = IDLE;
    else
    begin
      unique case (st_reg.phase)
        IDLE: ;
        SHIFT:
        begin
          if (scl_rise)
          begin
            st_next.shift = {st_reg.shift[6:0], sda_in};
            st_next.count = st_reg.count + 4'h1;
          end
          if (scl_fall && st_reg.count == BITS_PER_BYTE)
          begin
            st_next.phase     = ACK;
            st_next.ack_drive = 1'b0;
            if (st_reg.matched || (is_ten ? (st_reg.ten_hi ? addr_hit : hdr_hit)
                                          : addr_hit))
            begin
              // the ten-bit low byte carries address bit 0, not direction
              if (!st_reg.matched && !(is_ten && st_reg.ten_hi))
                st_next.rw = st_reg.shift[0];
              if (!st_reg.full && !st_reg.control_one[C1_OVERFLOW])
              begin
                st_next.buffer    = st_reg.shift;
                st_next.full      = 1'b1;
                st_next.ack_drive = 1'b1;
              end
              else if (st_reg.full)
                st_next.control_one[C1_OVERFLOW] = 1'b1;
              if (is_ten && !st_reg.matched && (st_reg.ten_hi || !st_reg.shift[0]))
                st_next.update = 1'b1;
              // header after repeated start with read: no update
              if (is_ten && !st_reg.ten_hi && !st_reg.shift[0])
                st_next.ten_hi = 1'b1;
              else
                st_next.matched = 1'b1;
              if (is_ten && st_reg.ten_hi && !st_reg.matched)
                st_next.ten_hi = 1'b0;
            end
            else
              st_next.phase = IDLE;
          end
        end
        ACK:
        begin
          if (scl_fall)
          begin
            st_next.flag      = 1'b1;
            st_next.ack_drive = 1'b0;
            st_next.count     = 4'h0;
            if (st_reg.rw && st_reg.matched)
            begin
              st_next.phase = SEND;
              st_next.tx    = tx_byte;
              st_next.control_one[C1_RELEASE] = 1'b0; // transmit always stretches
            end
            else
            begin
              st_next.phase = SHIFT;
              if (st_reg.control_two[C2_STRETCH] && st_reg.matched && !st_reg.ten_hi)
                st_next.control_one[C1_RELEASE] = 1'b0;
            end
          end
        end
        SEND:
        begin
          if (scl_fall && st_reg.count != 4'h0)
            st_next.tx = {st_reg.tx[6:0], 1'b1};
          if (scl_rise)
            st_next.count = st_reg.count + 4'h1;
          if (scl_rise && st_reg.count == BITS_PER_BYTE)
            st_next.phase = sda_in ? IDLE : ACK; // not-ack ends transfer
        end
        default: st_next.phase = IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg             <= '0;
      st_reg.phase       <= IDLE;
      st_reg.control_one <= RST_CONTROL_ONE;
      st_reg.control_two <= RST_CONTROL_TWO;
      st_reg.address     <= RST_ADDRESS;
      st_reg.scl_d       <= 1'b1;
      st_reg.sda_d       <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  // ---------------------------------------------------------------
  // pins and bus answer
  // ---------------------------------------------------------------
  always_comb
  begin
    scl_out = 1'b0;
    sda_out = 1'b0;
    // stretch needs also the ten-bit update hold
    scl_oe  = enabled && (slave_mode || is_master) &&
              ((!st_reg.control_one[C1_RELEASE] && st_reg.phase != IDLE) ||
               (st_reg.update && st_reg.phase == SHIFT && st_reg.count == 4'h0) ||
               st_reg.start_step[2]);
    sda_oe  = enabled && (slave_mode || is_master) &&
              (st_reg.ack_drive || (st_reg.phase == SEND && !st_reg.tx[7]) ||
               st_reg.start_step != 3'h0);
  end

  assign bus.prdata   = st_reg.rdata;
  assign bus.pready   = 1'b1;
  assign bus.pslverr  = 1'b0;
  assign bus.port_irq = st_reg.flag;
endmodule

/* File: verilog/i2c_software.sv */
// apb master issuing register commands to the serial port target
`timescale 1ns/1ps
module i2c_software
  import addr_match_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // register bus
  i2c_link_if.software     bus,
  // user command
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_addr,
  input  wire logic [31:0] cmd_wdata,
  output logic             cmd_ready,
  output logic             rsp_valid,
  output logic [31:0]      rsp_rdata
);
  typedef enum logic [2:0] {
    S_IDLE   = 3'b001,
    S_SETUP  = 3'b010,
    S_ACCESS = 3'b100
  } bus_e;

  typedef struct packed {
    bus_e        phase;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        done;
    logic [31:0] rdata;
  } state_s;

  state_s st_reg;
  state_s st_next;

  // ---------------------------------------------------------------
  // transfer sequencing: idle, setup, access
  // ---------------------------------------------------------------
  always_comb
  begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    unique case (st_reg.phase)
      S_IDLE:
        if (cmd_valid)
        begin
          st_next.phase = S_SETUP;
          st_next.write = cmd_write;
          st_next.addr  = cmd_addr;
          st_next.wdata = cmd_wdata;
        end
      S_SETUP: st_next.phase = S_ACCESS;
      S_ACCESS:
        if (bus.pready)
        begin
          st_next.phase = S_IDLE;
          st_next.done  = 1'b1;
          st_next.rdata = bus.prdata;
        end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg       <= '0;
      st_reg.phase <= S_IDLE;
    end
    else
      st_reg <= st_next;
  end

  assign bus.psel    = st_reg.phase != S_IDLE;
  assign bus.penable = st_reg.phase == S_ACCESS;
  assign bus.pwrite  = st_reg.write;
  assign bus.paddr   = st_reg.addr;
  assign bus.pwdata  = st_reg.wdata;
  assign cmd_ready   = st_reg.phase == S_IDLE;
  assign rsp_valid   = st_reg.done;
  assign rsp_rdata   = st_reg.rdata;
endmodule

/* File: tb/i2c_link_properties.sv */
// assertions on the register link and the serial bus pins
`timescale 1ns/1ps
module i2c_link_properties
  import addr_match_pkg::*;
(
  // clock and reset
  input logic        pclk,
  input logic        presetn,
  // register bus
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic        port_irq,
  // bus pins
  input logic        scl_in,
  input logic        sda_in,
  input logic        scl_out,
  input logic        scl_oe,
  input logic        sda_out,
  input logic        sda_oe
);
  // ----------------------
  // bit position tracker
  // ----------------------
  typedef struct packed {logic scl_q; logic sda_q; logic [3:0] cnt;} mon_s;
  mon_s mon_reg;
  mon_s mon_next;
  logic clr_hit;
  assign clr_hit = psel && penable && pwrite && paddr == OFF_FLAGS && pwdata[0];
  // start or stop restarts the count; the tenth rise is bit one of the next byte
  always_comb
  begin
    mon_next = mon_reg;
    mon_next.scl_q = scl_in;
    mon_next.sda_q = sda_in;
    if (scl_in && mon_reg.scl_q && sda_in != mon_reg.sda_q)
      mon_next.cnt = 4'h0;
    else if (scl_in && !mon_reg.scl_q)
      mon_next.cnt = (mon_reg.cnt == 4'h9) ? 4'h1 : mon_reg.cnt + 4'h1;
  end
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      mon_reg <= 6'h30;
    else
      mon_reg <= mon_next;
  // ----------------------
  // properties
  // ----------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence eighth_low;
    !scl_in && mon_reg.cnt == 4'h8;
  endsequence
  sequence ninth_low;
    !scl_in && mon_reg.cnt == 4'h9;
  endsequence
  chk_ack_after_eighth:
    assert property ($rose(sda_oe) |-> eighth_low) else $error("ack begun off the eighth low");
  chk_ack_ends_ninth:
    assert property ($fell(sda_oe) |-> ninth_low) else $error("ack not ended at ninth fall");
  chk_flag_at_ninth:
    assert property ($rose(port_irq) |-> ninth_low) else $error("flag raised off ninth fall");
  chk_shift_silent:
    assert property (mon_reg.cnt < 4'h8 |-> !sda_oe) else $error("data line pulled mid byte");
  chk_pins_pull_only:
    assert property (!scl_out && !sda_out) else $error("pin driven to a high level");
  chk_stretch_on_low:
    assert property ($rose(scl_oe) |-> !$past(scl_in)) else $error("clock held during high");
  chk_flag_sticky:
    assert property (port_irq && !clr_hit |=> port_irq) else $error("flag lost by itself");
  chk_flag_write_clear:
    assert property (clr_hit |=> !port_irq) else $error("flag not cleared by write");
endmodule

/* File: tb/tb.sv */
// self-checking bench: software master and serial port target on one link
`timescale 1ns/1ps
module tb
  import addr_match_pkg::*;
();
  logic        pclk;
  logic        presetn;
  logic        scl_m;
  logic        sda_m;
  logic [7:0]  tx_byte;
  logic        cmd_valid;
  logic        cmd_write;
  logic [7:0]  cmd_addr;
  logic [31:0] cmd_wdata;
  logic        cmd_ready;
  logic        rsp_valid;
  logic [31:0] rsp_rdata;
  logic        scl_out;
  logic        scl_oe;
  logic        sda_out;
  logic        sda_oe;
  logic [31:0] q;
  logic        ack;
  int          failures;
  int          n_checks;
  // pulled-up wires: whoever pulls low wins
  wire         scl_in = scl_m & ~scl_oe;
  wire         sda_in = sda_m & ~sda_oe;
  i2c_link_if  link ();
  i2c_target i2c_target_i (.pclk, .presetn, .bus(link.target), .scl_in, .sda_in,
    .scl_out, .scl_oe, .sda_out, .sda_oe, .tx_byte);
  i2c_software i2c_software_i (.pclk, .presetn, .bus(link.software), .cmd_valid,
    .cmd_write, .cmd_addr, .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_rdata);
  i2c_link_properties i2c_link_properties_i (.pclk, .presetn, .psel(link.psel),
    .penable(link.penable), .pwrite(link.pwrite), .paddr(link.paddr),
    .pwdata(link.pwdata), .port_irq(link.port_irq), .scl_in, .sda_in, .scl_out,
    .scl_oe, .sda_out, .sda_oe);
  always #5 pclk = ~pclk;
  // ----------------------
  // shared tasks
  // ----------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (failures == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic give_up;
    failures++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    complete_run();
  endtask
  task automatic reg_op(input logic wr_n, input logic [7:0] a, input logic [31:0] d);
    int k;
    cmd_valid <= 1'b1;
    cmd_write <= wr_n;
    cmd_addr <= a;
    cmd_wdata <= d;
    for (k = 0; k < 50; k++)
    begin
      @(posedge pclk);
      if (cmd_ready === 1'b1)
        break;
    end
    cmd_valid <= 1'b0;
    for (k = 0; k < 50 && rsp_valid !== 1'b1; k++)
      @(posedge pclk);
    if (rsp_valid !== 1'b1)
      give_up();
    q = rsp_rdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_op(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_op(1'b0, a, 32'h0);
  endtask
  // the target may stretch, so every rise waits for the wire
  task automatic scl_high;
    int k;
    scl_m <= 1'b1;
    for (k = 0; k < 400 && scl_in !== 1'b1; k++)
      @(posedge pclk);
    if (scl_in !== 1'b1)
      give_up();
    repeat (4) @(posedge pclk);
  endtask
  task automatic start_cond;
    sda_m <= 1'b1;
    repeat (2) @(posedge pclk);
    scl_high();
    sda_m <= 1'b0;
    repeat (4) @(posedge pclk);
    scl_m <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic stop_cond;
    sda_m <= 1'b0;
    repeat (2) @(posedge pclk);
    scl_high();
    sda_m <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  task automatic send_byte(input logic [7:0] b);
    logic [8:0] bits;
    int i;
    bits = {b, 1'b1};
    for (i = 8; i >= 0; i--)
    begin
      sda_m <= bits[i];
      repeat (2) @(posedge pclk);
      scl_high();
      if (i == 0)
        ack = ~sda_in;
      scl_m <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask
  task automatic frame(input logic [7:0] b);
    start_cond();
    send_byte(b);
    stop_cond();
  endtask
  // ----------------------
  // scenarios
  // ----------------------
  task automatic t_reset;
    rd(OFF_CONTROL_ONE);
    check(q, {24'h0, RST_CONTROL_ONE});
    rd(OFF_CONTROL_TWO);
    check(q, 32'h0);
    rd(OFF_ADDRESS);
    check(q, 32'h0);
    rd(8'h1C);
    check(q, 32'h0);
  endtask
  task automatic t_modes;
    logic [3:0] codes [6] = '{MODE_SLAVE10_SP, MODE_SLAVE7_SP, MODE_FW_MASTER,
                              MODE_MASTER, MODE_SLAVE10, MODE_SLAVE7};
    int i;
    for (i = 0; i < 6; i++)
    begin
      wr(OFF_CONTROL_ONE, {28'h1, codes[i]});
      rd(OFF_CONTROL_ONE);
      check(q, {28'h1, codes[i]});
    end
  endtask
  task automatic t_mask7;
    logic [7:0] addrs [5] = '{8'hA0, 8'hAE, 8'hA6, 8'hB0, 8'h20};
    logic [4:0] hits = 5'b00111;
    int i;
    wr(OFF_ADDRESS, 32'hA0);
    wr(OFF_CONTROL_TWO, 32'h0E);
    wr(OFF_CONTROL_ONE, 32'h36);
    for (i = 0; i < 5; i++)
    begin
      frame(addrs[i]);
      check({31'h0, ack}, {31'h0, hits[i]});
      rd(OFF_STATUS);
      check(q, {31'h0, hits[i]});
      rd(OFF_FLAGS);
      check(q, {31'h0, hits[i]});
      rd(OFF_BUFFER);
      check(q, {24'h0, hits[i] ? addrs[i] : 8'hA6});
      wr(OFF_FLAGS, 32'h1);
    end
  endtask
  task automatic t_overflow;
    frame(8'hA0);
    wr(OFF_FLAGS, 32'h1);
    frame(8'hA2);
    check({31'h0, ack}, 32'h0);
    rd(OFF_FLAGS);
    check(q, 32'h1);
    rd(OFF_CONTROL_ONE);
    check(q, 32'h76);
    rd(OFF_BUFFER);
    check(q, 32'hA0);
    frame(8'hA4);
    check({31'h0, ack}, 32'h0);
    wr(OFF_CONTROL_ONE, 32'h36);
    wr(OFF_FLAGS, 32'h1);
    frame(8'hA4);
    check({31'h0, ack}, 32'h1);
    rd(OFF_BUFFER);
    check(q, 32'hA4);
    wr(OFF_FLAGS, 32'h1);
  endtask
  task automatic t_ten_bit;
    wr(OFF_CONTROL_TWO, 32'h02);
    wr(OFF_ADDRESS, 32'hF2);
    wr(OFF_CONTROL_ONE, 32'h37);
    start_cond();
    send_byte({TEN_BIT_HEADER, 3'b010});
    check({31'h0, ack}, 32'h1);
    rd(OFF_STATUS);
    check(q, 32'h3);
    wr(OFF_ADDRESS, 32'h34);
    rd(OFF_STATUS);
    check(q, 32'h1);
    rd(OFF_BUFFER);
    wr(OFF_FLAGS, 32'h1);
    send_byte(8'h37);
    check({31'h0, ack}, 32'h1);
    rd(OFF_STATUS);
    check(q, 32'h3);
    wr(OFF_ADDRESS, 32'hF2);
    rd(OFF_BUFFER);
    check(q, 32'h37);
    stop_cond();
    wr(OFF_FLAGS, 32'h1);
  endtask
  task automatic t_stretch;
    wr(OFF_CONTROL_TWO, 32'h01);
    wr(OFF_ADDRESS, 32'hA0);
    wr(OFF_CONTROL_ONE, 32'h36);
    start_cond();
    send_byte(8'hA0);
    rd(OFF_BUFFER);
    wr(OFF_FLAGS, 32'h1);
    wr(OFF_CONTROL_ONE, 32'h36);
    send_byte(8'h5A);
    check({31'h0, ack}, 32'h1);
    // data held low so the later release of the clock ends in a stop
    sda_m <= 1'b0;
    scl_m <= 1'b1;
    repeat (20) @(posedge pclk);
    check({31'h0, scl_in}, 32'h0);
    rd(OFF_BUFFER);
    check(q, 32'h5A);
    wr(OFF_CONTROL_ONE, 32'h36);
    repeat (4) @(posedge pclk);
    check({31'h0, scl_in}, 32'h1);
    sda_m <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    scl_m = 1'b1;
    sda_m = 1'b1;
    tx_byte = 8'h00;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 8'h00;
    cmd_wdata = 32'h0;
    failures = 0;
    n_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_modes();
    t_mask7();
    t_overflow();
    t_ten_bit();
    t_stretch();
    complete_run();
  end
endmodule
